// ### hw/mcr_pkg.sv
`default_nettype none
package mcr_pkg;
   // register addresses
   localparam logic [6:0] ADDR_INPUT_RANGE = 7'h38;
   localparam logic [6:0] ADDR_OUT_CLEAR = 7'h39;
   localparam logic [6:0] ADDR_UPDATE_MODE = 7'h3a;
   localparam logic [6:0] ADDR_POWER = 7'h3b;
   localparam logic [6:0] ADDR_RESET_KEY = 7'h3e;
   localparam logic [6:0] ADDR_IDENT = 7'h40;
   // reset values
   localparam logic [15:0] RST_INPUT_RANGE = 16'hff00;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   // writable masks: reserved bits stay zero
   localparam logic [15:0] MASK_INPUT_RANGE = 16'hff00;
   localparam logic [15:0] MASK_OUT_CHAN = 16'h000f;
   localparam logic [15:0] MASK_POWER = 16'h7e00;
   // power field positions
   localparam int POS_ADC_POWER = 14;
   localparam int POS_REF_POWER = 13;
   localparam int POS_OUT0_POWER = 12;
   localparam int POS_OUT3_POWER = 9;
   // reset key and block time
   localparam logic [15:0] RESET_KEY = 16'h6600;
   localparam int CLK_MHZ = 200;
   localparam int RESET_BLOCK_US = 30;
   localparam int RESET_BLOCK_CYC = RESET_BLOCK_US * CLK_MHZ;
endpackage
`default_nettype wire

// ### hw/mcr_field_reg.sv
`default_nettype none
// masked 16-bit register cell
module mcr_field_reg
   import mcr_pkg::*;
#(
   parameter logic [15:0] RESET_VAL = 16'h0000,
   parameter logic [15:0] MASK = 16'hffff
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic soft_clear,
   input wire logic wr_en,
   input wire logic [15:0] wr_data,
   output logic [15:0] value
);
   // reserved bits never store
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         value <= RESET_VAL;
      end else if (soft_clear) begin
         value <= RESET_VAL;
      end else if (wr_en) begin
         value <= wr_data & MASK;
      end
   end
endmodule
`default_nettype wire

// ### hw/mcr_config_regs.sv
`default_nettype none
// What this block does
// - clear bit zero lets that output run normally
// - update-mode bit one is synchronous, zero asynchronous, per channel
// - power bit 14 turns primary converter on; resets to zero
// - power bit 13 enables reference buffer and drives the reference pin
// - power bits 12..9 enable outputs 0..3; off means high impedance
// - only key 0x6600 written to the reset register starts a full reset
// - serial accesses are ignored while the soft reset runs
// - identifier register is fixed, read-only, writes ignored
// - input-range resets to 0xff00, the others except the fixed identifier to zero
// - reserved bits of clear, update-mode and power reset to zero
module mcr_config_regs
   import mcr_pkg::*;
#(
   parameter logic [15:0] PART_ID = 16'h0a5a, // arbitrary value
   parameter int BLOCK_CYC = RESET_BLOCK_CYC
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [6:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   output logic serial_blocked,
   output logic soft_reset_pulse,
   output logic [7:0] input_range,
   output logic [3:0] analog_output_force_zero,
   output logic [3:0] analog_output_update_mode,
   output logic [3:0] analog_output_n_enable,
   output logic adc_power,
   output logic ref_buffer_on,
   output logic ref_pin_drive
);
   localparam int CW = $clog2(BLOCK_CYC + 1);

   // refuse settings the logic cannot serve: a window of zero cycles would
   // never block, and the enable decode below assumes the power field layout
   if (BLOCK_CYC < 1) begin : g_bad_block
      $error("block time must be at least one cycle");
   end
   if (POS_OUT0_POWER - POS_OUT3_POWER != 3) begin : g_bad_outputs
      $error("output enables must sit in four adjacent power bits");
   end
   if (!MASK_POWER[POS_ADC_POWER] || !MASK_POWER[POS_OUT3_POWER]) begin : g_bad_mask
      $error("power mask must keep the converter and output enable bits");
   end

   // register map, all words 16 bits
   //    0x38 input range, bits 15:8, resets to 0xff00
   //    0x39 output clear, bits 3:0, resets to zero
   //    0x3a update mode, bits 3:0, resets to zero
   //    0x3b power, bits 14:9, resets to zero
   //    0x3e reset key, any other word stored, the key itself starts a reset
   //    0x40 identifier, fixed, writes dropped

   logic [CW-1:0] block_cnt;
   logic [15:0] range_q;
   logic [15:0] clear_q;
   logic [15:0] mode_q;
   logic [15:0] power_q;
   logic [15:0] key_q;
   logic [15:0] next_rdata;

   // address decode, one select per mapped register; at most one is high,
   // so the read mux needs no priority and unmapped words read zero
   wire sel_range = (reg_addr == ADDR_INPUT_RANGE);
   wire sel_clear = (reg_addr == ADDR_OUT_CLEAR);
   wire sel_mode = (reg_addr == ADDR_UPDATE_MODE);
   wire sel_power = (reg_addr == ADDR_POWER);
   wire sel_key = (reg_addr == ADDR_RESET_KEY);
   wire sel_ident = (reg_addr == ADDR_IDENT);

   // requests are dropped while the reset runs; the host gets no answer,
   // which is how it tells a blocked read from a read of zero
   wire acc_ok = !serial_blocked;
   wire wr_ok = reg_wr && acc_ok;
   wire rd_ok = reg_rd && acc_ok;

   // write strobes; the identifier has none, so a write there is lost
   wire wr_range = wr_ok && sel_range;
   wire wr_clear = wr_ok && sel_clear;
   wire wr_mode = wr_ok && sel_mode;
   wire wr_power = wr_ok && sel_power;
   wire wr_key = wr_ok && sel_key;

   // only the full key word starts the reset; a near miss is just stored
   wire key_match = (reg_wdata == RESET_KEY);
   wire key_hit = wr_key && key_match;
   wire key_store = wr_key && !key_match;

   // window is open while the counter is not yet back at zero
   assign serial_blocked = (block_cnt != '0);

   // soft reset returns every register to its reset value on the key edge;
   // the window then keeps writes out until the host may talk again
   wire soft_clear = key_hit;

   // input range keeps only its high byte; the low byte is reserved
   mcr_field_reg #(
      .RESET_VAL(RST_INPUT_RANGE),
      .MASK(MASK_INPUT_RANGE)
   ) u_range (
      .mclk(mclk),
      .resetn(resetn),
      .soft_clear(soft_clear),
      .wr_en(wr_range),
      .wr_data(reg_wdata),
      .value(range_q)
   );

   // output clear bits, one per channel
   mcr_field_reg #(
      .RESET_VAL(RST_ZERO),
      .MASK(MASK_OUT_CHAN)
   ) u_clear (
      .mclk(mclk),
      .resetn(resetn),
      .soft_clear(soft_clear),
      .wr_en(wr_clear),
      .wr_data(reg_wdata),
      .value(clear_q)
   );

   // update-mode bits, one per channel
   mcr_field_reg #(
      .RESET_VAL(RST_ZERO),
      .MASK(MASK_OUT_CHAN)
   ) u_mode (
      .mclk(mclk),
      .resetn(resetn),
      .soft_clear(soft_clear),
      .wr_en(wr_mode),
      .wr_data(reg_wdata),
      .value(mode_q)
   );

   // power bits; bit 15 and the low nine bits never store
   mcr_field_reg #(
      .RESET_VAL(RST_ZERO),
      .MASK(MASK_POWER)
   ) u_power (
      .mclk(mclk),
      .resetn(resetn),
      .soft_clear(soft_clear),
      .wr_en(wr_power),
      .wr_data(reg_wdata),
      .value(power_q)
   );

   // key register holds last value written; the reset itself zeroes it,
   // so a read after the window shows zero rather than the key
   mcr_field_reg #(
      .RESET_VAL(RST_ZERO),
      .MASK(16'hffff)
   ) u_key (
      .mclk(mclk),
      .resetn(resetn),
      .soft_clear(soft_clear),
      .wr_en(key_store),
      .wr_data(reg_wdata),
      .value(key_q)
   );

   // blocking window counter, host must honour it anyway
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         block_cnt <= '0;
      end else if (key_hit) begin
         block_cnt <= CW'(BLOCK_CYC);
      end else if (serial_blocked) begin
         block_cnt <= block_cnt - 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         soft_reset_pulse <= 1'b0;
      end else begin
         soft_reset_pulse <= key_hit;
      end
   end

   // identifier is a wired constant with no storage behind it
   wire [15:0] part_identifier_field = PART_ID;

   // read mux as an and-or of the one-hot selects
   assign next_rdata = ({16{sel_range}} & range_q)
      | ({16{sel_clear}} & clear_q)
      | ({16{sel_mode}} & mode_q)
      | ({16{sel_power}} & power_q)
      | ({16{sel_key}} & key_q)
      | ({16{sel_ident}} & part_identifier_field);

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= rd_ok;
         if (rd_ok) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // per-channel clear bits, named after the output they steer
   wire out0_force_zero = clear_q[0];
   wire out1_force_zero = clear_q[1];
   wire out2_force_zero = clear_q[2];
   wire out3_force_zero = clear_q[3];

   // per-channel update-mode bits
   wire out0_update_mode = mode_q[0];
   wire out1_update_mode = mode_q[1];
   wire out2_update_mode = mode_q[2];
   wire out3_update_mode = mode_q[3];

   // power enables run downwards: bit 12 is output 0, bit 9 is output 3
   wire out0_power = power_q[POS_OUT0_POWER];
   wire out1_power = power_q[POS_OUT0_POWER - 1];
   wire out2_power = power_q[POS_OUT0_POWER - 2];
   wire out3_power = power_q[POS_OUT3_POWER];

   // range field drives the input scaling
   assign input_range = range_q[15:8];

   // a set clear bit overrides the output until it is written back to zero
   assign analog_output_force_zero = {out3_force_zero, out2_force_zero, out1_force_zero,
      out0_force_zero};

   // one selects synchronous update, zero asynchronous
   assign analog_output_update_mode = {out3_update_mode, out2_update_mode, out1_update_mode,
      out0_update_mode};

   // a low enable leaves that output floating in the analog section
   assign analog_output_n_enable = {out3_power, out2_power, out1_power, out0_power};

   // converter follows its power bit directly
   assign adc_power = power_q[POS_ADC_POWER];

   // with the buffer off the pin is left as an input for an outside reference
   assign ref_buffer_on = power_q[POS_REF_POWER];
   assign ref_pin_drive = power_q[POS_REF_POWER];
endmodule
`default_nettype wire

// ### tb/mcr_config_regs_asserts.sv
`default_nettype none
// port checker; a request seen while blocked never counts as taken
module mcr_config_regs_asserts
   import mcr_pkg::*;
#(parameter int BLOCK_CYC = 8) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [6:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_rvalid,
   input wire logic serial_blocked,
   input wire logic soft_reset_pulse,
   input wire logic [3:0] analog_output_force_zero,
   input wire logic [3:0] analog_output_update_mode,
   input wire logic [3:0] analog_output_n_enable,
   input wire logic adc_power
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // accepted writes; power bits 12..9 land on enables 0..3
   wire w = reg_wr && !serial_blocked;
   wire wk = w && reg_addr == ADDR_RESET_KEY && reg_wdata == RESET_KEY;
   wire wp = w && reg_addr == ADDR_POWER;
   wire [3:0] pe = {reg_wdata[9], reg_wdata[10], reg_wdata[11], reg_wdata[12]};
   AST_CLEAR: assert property (w && reg_addr == ADDR_OUT_CLEAR |=>
      analog_output_force_zero == $past(reg_wdata[3:0])) else $error("clear bits wrong");
   AST_MODE: assert property (w && reg_addr == ADDR_UPDATE_MODE |=>
      analog_output_update_mode == $past(reg_wdata[3:0])) else $error("mode bits wrong");
   AST_ADC: assert property (wp |=> adc_power == $past(reg_wdata[14]))
      else $error("adc power wrong");
   AST_OUTP: assert property (wp |=> analog_output_n_enable == $past(pe))
      else $error("output enables wrong");
   AST_KEY: assert property (wk |=> serial_blocked[*8] ##1 !serial_blocked)
      else $error("block window wrong");
   AST_PULSE: assert property (soft_reset_pulse |-> $past(wk))
      else $error("reset without key");
   AST_RST: assert property (wk |=> soft_reset_pulse
      && analog_output_force_zero == 4'h0
      && analog_output_update_mode == 4'h0 && !adc_power) else $error("soft reset incomplete");
   AST_DROP: assert property (serial_blocked && reg_rd |=> !reg_rvalid)
      else $error("read answered while blocked");
   cover property (wk);
   cover property (serial_blocked && reg_rd);
   // window length for any block time, counted instead of unrolled
   logic [15:0] win_cnt;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         win_cnt <= 16'h0000;
      end else if (wk) begin
         win_cnt <= 16'h0000;
      end else if (serial_blocked) begin
         win_cnt <= win_cnt + 16'h0001;
      end
   end
   AST_WINDOW: assert property ($fell(serial_blocked) |-> win_cnt == 16'(BLOCK_CYC))
      else $error("block window length wrong");
   cover property (wp);
   cover property ($fell(serial_blocked));
endmodule
bind mcr_config_regs mcr_config_regs_asserts #(.BLOCK_CYC(BLOCK_CYC)) u_chk (.*);
`default_nettype wire

// ### tb/mcr_host.sv
`default_nettype none
// host on the register port; changes lines only on falling edges
module mcr_host (
   input wire logic mclk,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic serial_blocked,
   output logic reg_wr,
   output logic reg_rd,
   output logic [6:0] reg_addr,
   output logic [15:0] reg_wdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
   // one-cycle write; data inverted after release so stale bits never match
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(negedge mclk);
      {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      @(negedge mclk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   // answer sampled one edge after the request is taken
   task automatic rd(input logic [6:0] a, output logic v, output logic [15:0] d);
      @(negedge mclk);
      {reg_rd, reg_addr} = {1'b1, a};
      @(negedge mclk);
      {v, d} = {reg_rvalid, reg_rdata};
      reg_rd = 1'b0;
   endtask
   // bounded wait for the soft reset window to close
   task automatic hold_off();
      repeat (50) if (serial_blocked) @(negedge mclk);
   endtask
endmodule
`default_nettype wire

// ### tb/mcr_config_regs_test.sv
`default_nettype none
module mcr_config_regs_test;
   timeunit 1ns;
   timeprecision 100ps;
   import mcr_pkg::*;
   localparam logic [15:0] ID = 16'h1234; // arbitrary value
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic v;
   logic [15:0] d;
   int err_total = 0;
   int samples_checked = 0;
   wire logic reg_wr, reg_rd, reg_rvalid, serial_blocked, soft_reset_pulse;
   wire logic adc_power, ref_buffer_on, ref_pin_drive;
   wire logic [6:0] reg_addr;
   wire logic [15:0] reg_wdata, reg_rdata;
   wire logic [7:0] input_range;
   wire logic [3:0] analog_output_force_zero, analog_output_update_mode, analog_output_n_enable;
   wire logic [6:0] pwr_pins;
   // converter, reference buffer, reference pin, then enables 3 down to 0
   assign pwr_pins = {adc_power, ref_buffer_on, ref_pin_drive, analog_output_n_enable};
   always #2.5 mclk = ~mclk;
   mcr_config_regs #(.PART_ID(ID), .BLOCK_CYC(8)) u_dut (.*);
   mcr_host u_host (.*);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // read that must be answered with the given word
   task automatic rc(input logic [6:0] a, input logic [15:0] e);
      u_host.rd(a, v, d);
      chk(16'(v), 16'h0001);
      chk(d, e);
   endtask
   task automatic t_reset();
      rc(ADDR_INPUT_RANGE, RST_INPUT_RANGE);
      chk(16'(input_range), 16'h00ff);
      rc(ADDR_OUT_CLEAR, RST_ZERO);
      rc(ADDR_UPDATE_MODE, RST_ZERO);
      rc(ADDR_POWER, RST_ZERO);
      rc(ADDR_RESET_KEY, RST_ZERO);
      rc(ADDR_IDENT, ID);
      rc(7'h3c, RST_ZERO);
   endtask
   // all ones (0x00ff to input range), then uneven patterns so a swapped clear or power bit order shows
   task automatic t_fields();
      u_host.wr(ADDR_OUT_CLEAR, 16'hffff);
      u_host.wr(ADDR_UPDATE_MODE, 16'hffff);
      u_host.wr(ADDR_POWER, 16'hffff);
      u_host.wr(ADDR_INPUT_RANGE, 16'h00ff);
      u_host.wr(ADDR_IDENT, 16'hffff);
      rc(ADDR_OUT_CLEAR, 16'h000f);
      rc(ADDR_POWER, 16'h7e00);
      rc(ADDR_IDENT, ID);
      rc(ADDR_INPUT_RANGE, 16'h0000);
      chk(16'(input_range), 16'h0000);
      chk(16'({analog_output_force_zero, analog_output_update_mode}), 16'h00ff);
      chk(16'(pwr_pins), 16'h007f);
      u_host.wr(ADDR_POWER, 16'h5400);
      u_host.wr(ADDR_OUT_CLEAR, 16'h0005);
      u_host.wr(ADDR_UPDATE_MODE, 16'h0006);
      chk(16'(pwr_pins), 16'h0045);
      chk(16'(analog_output_force_zero), 16'h0005);
      chk(16'(analog_output_update_mode), 16'h0006);
   endtask
   task automatic t_key();
      u_host.wr(ADDR_RESET_KEY, 16'h6601);
      chk(16'({soft_reset_pulse, serial_blocked}), 16'h0000);
      rc(ADDR_RESET_KEY, 16'h6601);
      u_host.wr(ADDR_RESET_KEY, RESET_KEY);
      chk(16'({soft_reset_pulse, serial_blocked}), 16'h0003);
      u_host.rd(ADDR_IDENT, v, d);
      chk(16'(v), 16'h0000);
      // write inside the window must be lost, seen by the power read below
      u_host.wr(ADDR_POWER, 16'hffff);
      u_host.hold_off();
      chk(16'(serial_blocked), 16'h0000);
      chk(16'({analog_output_force_zero, analog_output_update_mode}), 16'h0000);
      rc(ADDR_INPUT_RANGE, RST_INPUT_RANGE);
      rc(ADDR_POWER, RST_ZERO);
      rc(ADDR_RESET_KEY, RST_ZERO);
   endtask
   task automatic finish_test();
      $display("checks=%0d errors=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge mclk);
      resetn = 1'b1;
      t_reset();
      t_fields();
      t_key();
      finish_test();
   end
   // watchdog well past the sixty or so cycles the tests need
   initial begin
      #20000;
      err_total++;
      finish_test();
   end
endmodule
`default_nettype wire
